// [ssc_pkg.sv]
/*
 * ssc_pkg: constants and types shared by the sensor end and the host end of the
 * standby and output control link.
 * assumes: both ends run on one clock, pclk at 40 MHz.
 */
package ssc_pkg;
   // sensor register map, word index on the sensor's own register port
   localparam logic [7:0]  SSC_REG_OUT_CTRL  = 8'h0D;
   localparam logic [7:0]  SSC_REG_CLK_BYP   = 8'h65;
   localparam logic [15:0] SSC_OUT_CTRL_RST  = 16'h0000;
   localparam logic [15:0] SSC_CLK_BYP_RST   = 16'h0000;
   // output_and_standby_control fields; SSC_BIT_BYPASS is bit 0 of the clock bypass register
   localparam int SSC_BIT_RESTART   = 1;
   localparam int SSC_BIT_STANDBY   = 2;
   localparam int SSC_BIT_OUT_DIS   = 4;
   localparam int SSC_BIT_FORCE_DRV = 6;
   localparam int SSC_BIT_PIN_IGN   = 7;
   localparam int SSC_BIT_BYPASS    = 0;
   localparam logic [15:0] SSC_OUT_CTRL_MASK = 16'h00D4;
   // readout geometry, in pixel clocks and rows
   localparam int SSC_DATA_W = 10;
   localparam int SSC_CNT_W  = 6;
   localparam logic [5:0] SSC_LINE_ACT   = 6'h10;
   localparam logic [5:0] SSC_LINE_TOTAL = 6'h14;
   localparam logic [5:0] SSC_ROW_ACT    = 6'h08;
   localparam logic [5:0] SSC_ROW_TOTAL  = 6'h0A;
   localparam int SSC_DOM_N = 4;
   // master clock cycles the host waits after both qualifiers fall
   localparam int          SSC_MCLK_STOP_CYC = 2;
   localparam logic [1:0]  SSC_MCLK_STOP_CNT = 2'(SSC_MCLK_STOP_CYC);
   // host APB register map, byte addresses
   localparam logic [7:0] SSC_APB_CTRL   = 8'h00;
   localparam logic [7:0] SSC_APB_CMD    = 8'h04;
   localparam logic [7:0] SSC_APB_STATUS = 8'h08;
   localparam int SSC_CTRL_STBY = 0;
   localparam int SSC_CTRL_MCLK = 1;
   localparam int SSC_CMD_WE    = 24;
   localparam int SSC_ST_BUSY   = 0;
   localparam int SSC_ST_FV     = 1;
   localparam int SSC_ST_LV     = 2;
   localparam int SSC_ST_MCLK   = 3;
   localparam logic [1:0] SSC_CTRL_RST = 2'h2;

   typedef enum logic [2:0] {
      SSC_RUN, SSC_ROW_END, SSC_GATE_OFF, SSC_ANA_OFF,
      SSC_STBY, SSC_CLK_ON, SSC_ANA_ON, SSC_RESTART
   } ssc_pwr_type;
endpackage

// [ssc_link_if.sv]
/*
 * ssc_link_if: the pins between sensor and host, plus the sensor register port.
 * assumes: the bench resolves each two-way pin from its output and enable;
 * an enable ending in _oe_n is low while the sensor drives the pin.
 */
`timescale 1ns/1ps
interface ssc_link_if;
   logic [9:0]  pix_data;
   logic [9:0]  pix_data_oe_n;
   logic        frame_qual;
   logic        frame_qual_oe_n;
   logic        line_qual;
   logic        line_qual_oe_n;
   logic        pixel_clock_out;
   logic        pixel_clock_oe_n;
   logic        strobe_out;
   logic        strobe_oe_n;
   logic        diff_out;
   logic        diff_oe_n;
   logic        low_power_req;
   logic        master_clock_run;
   logic        reg_req;
   logic        reg_we;
   logic [7:0]  reg_addr;
   logic [15:0] reg_wdata;
   logic [15:0] reg_rdata;
   logic        reg_ack;

   modport dev  (output pix_data, pix_data_oe_n, frame_qual, frame_qual_oe_n, line_qual,
                 line_qual_oe_n, pixel_clock_out, pixel_clock_oe_n, strobe_out,
                 strobe_oe_n, diff_out, diff_oe_n, reg_rdata, reg_ack,
                 input low_power_req, master_clock_run, reg_req, reg_we, reg_addr,
                 reg_wdata);
   modport host (input pix_data, frame_qual, line_qual, pixel_clock_out, strobe_out,
                 reg_rdata, reg_ack,
                 output low_power_req, master_clock_run, reg_req, reg_we, reg_addr,
                 reg_wdata);
endinterface // ssc_link_if

// [ssc_sensor.sv]
/*
 * ssc_sensor: sensor end. readout timing, output enables, standby sequencer,
 * clock gating controls and the two sensor control registers.
 * assumes: pclk stands in for the master clock; master_clock_run tells whether
 * the host lets it run; the host holds reg_req until reg_ack.
 */
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
module ssc_sensor
   import ssc_pkg::*;
(
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   ssc_link_if.dev                   link,
   input  wire logic                 serial_mode,
   input  wire logic                 strobe_req,
   output logic [SSC_DOM_N-1:0]      dom_clk_en,
   output logic                      analog_on,
   output logic                      bias_on,
   output logic                      standby_active,
   output logic                      tc_restart
);

   typedef struct packed {
      ssc_pwr_type          pwr;
      logic [15:0]          out_ctrl;
      logic [15:0]          clk_byp;
      logic                 pin_s1;
      logic                 pin_s2;
      logic                 run_s1;
      logic                 run_s2;
      logic                 src_pin;
      logic [SSC_CNT_W-1:0] col;
      logic [SSC_CNT_W-1:0] row;
      logic                 pclk_out;
      logic [9:0]           data;
      logic                 fv;
      logic                 lv;
      logic                 strobe;
      logic                 analog;
      logic                 restart;
      logic [15:0]          rdata;
      logic                 ack;
   } ssc_sen_state_type;

   ssc_sen_state_type st_r;
   ssc_sen_state_type st_nxt;

   logic drive_par;
   logic req_pin;
   logic req_reg;
   logic low_power;

   // true from SSC_GATE_OFF through SSC_CLK_ON; not in SSC_ROW_END, SSC_ANA_ON or SSC_RESTART
   function automatic logic ssc_is_low_power(input ssc_pwr_type p);
      return (p == SSC_GATE_OFF) || (p == SSC_ANA_OFF) || (p == SSC_STBY) ||
             (p == SSC_CLK_ON);
   endfunction

   //////////////////////////////////////////////////////////////////////////////
   // output enables: straight from the raw pin so bus sharing needs no clock
   assign drive_par = ~st_r.out_ctrl[SSC_BIT_OUT_DIS] &
                      (st_r.out_ctrl[SSC_BIT_FORCE_DRV] | ~link.low_power_req);
   assign link.pix_data_oe_n    = {SSC_DATA_W{serial_mode | ~drive_par}};
   assign link.frame_qual_oe_n  = serial_mode | ~drive_par;
   assign link.line_qual_oe_n   = serial_mode | ~drive_par;
   assign link.pixel_clock_oe_n = serial_mode | ~drive_par;
   assign link.strobe_oe_n      = ~serial_mode & ~drive_par;
   assign link.diff_oe_n        = ~serial_mode;
   assign link.diff_out         = st_r.data[0] ^ st_r.lv;

   // pixel side data comes from flip-flops only
   assign link.pix_data        = st_r.data;
   assign link.frame_qual      = st_r.fv;
   assign link.line_qual       = st_r.lv;
   assign link.pixel_clock_out = st_r.pclk_out;
   assign link.strobe_out      = st_r.strobe;
   assign link.reg_rdata       = st_r.rdata;
   assign link.reg_ack         = st_r.ack;

   //////////////////////////////////////////////////////////////////////////////
   // user side controls
   assign low_power      = ssc_is_low_power(st_r.pwr);
   assign standby_active = low_power;
   assign analog_on      = st_r.analog;
   assign bias_on        = st_r.analog;
   assign tc_restart     = st_r.restart;
   // bypass wins over gating so a debug setup sees every domain clocked
   assign dom_clk_en = st_r.clk_byp[SSC_BIT_BYPASS] ? {SSC_DOM_N{1'b1}} :
                       {SSC_DOM_N{~low_power}};

   // standby sources; the pin only counts through its synchroniser
   assign req_pin = st_r.pin_s2 & ~st_r.out_ctrl[SSC_BIT_PIN_IGN];
   assign req_reg = st_r.out_ctrl[SSC_BIT_STANDBY];

   //////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      st_nxt         = st_r;
      st_nxt.pin_s1  = link.low_power_req;
      st_nxt.pin_s2  = st_r.pin_s1;
      st_nxt.run_s1  = link.master_clock_run;
      st_nxt.run_s2  = st_r.run_s1;
      st_nxt.ack     = 1'b0;
      st_nxt.restart = 1'b0;
      st_nxt.out_ctrl[SSC_BIT_RESTART] = 1'b0;

      // register port: silent while parked with the master clock stopped
      if (link.reg_req && !st_r.ack && !(low_power && !st_r.run_s2)) begin
         st_nxt.ack = 1'b1;
         if (link.reg_we) begin
            if (link.reg_addr == SSC_REG_OUT_CTRL) begin
               st_nxt.out_ctrl = link.reg_wdata & SSC_OUT_CTRL_MASK;
               st_nxt.restart  = link.reg_wdata[SSC_BIT_RESTART];
            end
            if (link.reg_addr == SSC_REG_CLK_BYP) begin
               st_nxt.clk_byp = link.reg_wdata;
            end
            st_nxt.rdata = link.reg_wdata;
         end else begin
            unique case (link.reg_addr)
               SSC_REG_OUT_CTRL: st_nxt.rdata = st_r.out_ctrl;
               SSC_REG_CLK_BYP:  st_nxt.rdata = st_r.clk_byp;
               default:          st_nxt.rdata = 16'h0000;
            endcase
         end
      end

      // readout timing, advances once per pixel clock period
      st_nxt.strobe = strobe_req;
      if (!low_power) begin
         st_nxt.pclk_out = ~st_r.pclk_out;
         if (st_r.pclk_out) begin
            if (st_r.col == SSC_LINE_TOTAL - 6'h01) begin
               st_nxt.col = '0;
               st_nxt.row = (st_r.row == SSC_ROW_TOTAL - 6'h01) ? '0 :
                            SSC_CNT_W'(st_r.row + 6'h01);
            end else begin
               st_nxt.col = SSC_CNT_W'(st_r.col + 6'h01);
            end
            st_nxt.lv   = (st_nxt.col < SSC_LINE_ACT) && (st_nxt.row < SSC_ROW_ACT);
            st_nxt.fv   = st_nxt.row < SSC_ROW_ACT;
            st_nxt.data = st_nxt.lv ? {st_nxt.row[3:0], st_nxt.col} : 10'h000;
         end
      end else begin
         st_nxt.pclk_out = 1'b1;
         st_nxt.data     = 10'h000;
         st_nxt.fv       = 1'b0;
         st_nxt.lv       = 1'b0;
         st_nxt.strobe   = 1'b0;
      end

      // standby sequencer; once left RUN nothing looks at the request until STBY
      unique case (st_r.pwr)
         SSC_RUN: begin
            if (req_pin || req_reg) begin
               st_nxt.pwr     = SSC_ROW_END;
               st_nxt.src_pin = req_pin;
            end
         end
         SSC_ROW_END: begin
            if (!st_r.lv && !st_r.pclk_out) begin
               st_nxt.pwr = SSC_GATE_OFF;
            end
         end
         SSC_GATE_OFF: st_nxt.pwr = SSC_ANA_OFF;
         SSC_ANA_OFF: begin
            st_nxt.analog = 1'b0;
            st_nxt.pwr    = SSC_STBY;
         end
         SSC_STBY: begin
            // leave only when the source that caused entry is gone
            if (st_r.src_pin ? !st_r.pin_s2 : !req_reg) begin
               st_nxt.pwr = SSC_CLK_ON;
            end
         end
         SSC_CLK_ON: st_nxt.pwr = SSC_ANA_ON;
         SSC_ANA_ON: begin
            st_nxt.analog = 1'b1;
            st_nxt.pwr    = SSC_RESTART;
         end
         SSC_RESTART: begin
            st_nxt.restart = 1'b1;
            st_nxt.pwr     = SSC_RUN;
         end
      endcase

      // timing restart, by register bit or at standby exit, starts a new frame
      if (st_r.restart) begin
         st_nxt.col      = '0;
         st_nxt.row      = '0;
         st_nxt.pclk_out = 1'b0;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // state register; the control registers sit here and keep their contents
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r          <= '0;
         st_r.pwr      <= SSC_RUN;
         st_r.out_ctrl <= SSC_OUT_CTRL_RST;
         st_r.clk_byp  <= SSC_CLK_BYP_RST;
         st_r.analog   <= 1'b1;
         st_r.run_s1   <= 1'b1;
         st_r.run_s2   <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

endmodule // ssc_sensor

// [ssc_host.sv]
/*
 * ssc_host: host end. APB slave with control, command and status words; it
 * drives the standby pin and the master clock run level and forwards sensor
 * register accesses.
 * assumes: APB master on the same pclk; link qualifiers are same-clock logic.
 */
`timescale 1ns/1ps
module ssc_host
   import ssc_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   ssc_link_if.host         link
);

   typedef struct packed {
      logic [1:0]  ctrl;
      logic        pin;
      logic        mclk;
      logic [1:0]  quiet;
      logic        busy;
      logic        we;
      logic [7:0]  addr;
      logic [15:0] wdata;
      logic [15:0] rdata;
      logic [31:0] prdata;
   } ssc_host_state_type;

   ssc_host_state_type st_r;
   ssc_host_state_type st_nxt;

   logic wr_acc;
   logic rd_acc;

   assign wr_acc  = psel & penable & pwrite;
   assign rd_acc  = psel & ~penable & ~pwrite;
   assign pready  = 1'b1;
   assign pslverr = 1'b0;
   assign prdata  = st_r.prdata;

   assign link.low_power_req    = st_r.pin;
   assign link.master_clock_run = st_r.mclk;
   assign link.reg_req          = st_r.busy;
   assign link.reg_we           = st_r.we;
   assign link.reg_addr         = st_r.addr;
   assign link.reg_wdata        = st_r.wdata;

   //////////////////////////////////////////////////////////////////////////////
   // APB decode, pin and clock sequencing, sensor register forwarding
   always_comb begin
      st_nxt = st_r;
      if (wr_acc && paddr == SSC_APB_CTRL) begin
         st_nxt.ctrl = pwdata[1:0];
      end
      // a command while busy is dropped; software polls busy first
      if (wr_acc && paddr == SSC_APB_CMD && !st_r.busy) begin
         st_nxt.busy  = 1'b1;
         st_nxt.addr  = pwdata[7:0];
         st_nxt.wdata = pwdata[23:8];
         st_nxt.we    = pwdata[SSC_CMD_WE];
      end
      if (st_r.busy && link.reg_ack) begin
         st_nxt.busy  = 1'b0;
         st_nxt.rdata = link.reg_rdata;
      end
      // read data is taken in setup so it stands through the access phase
      if (rd_acc) begin
         unique case (paddr)
            SSC_APB_CTRL:   st_nxt.prdata = {30'h0, st_r.ctrl};
            SSC_APB_STATUS: st_nxt.prdata = {st_r.rdata, 12'h000, st_r.mclk,
                                             link.line_qual, link.frame_qual, st_r.busy};
            default:        st_nxt.prdata = 32'h0000_0000;
         endcase
      end

      // release: clock back first, pin dropped only once it runs
      if (!st_r.ctrl[SSC_CTRL_STBY] || st_r.ctrl[SSC_CTRL_MCLK]) begin
         st_nxt.mclk = 1'b1;
      end
      st_nxt.pin = st_r.ctrl[SSC_CTRL_STBY] | (st_r.pin & ~st_r.mclk);

      // stop the clock only after the qualifiers stay low for the wait count
      if (st_r.pin && !link.frame_qual && !link.line_qual) begin
         if (st_r.quiet != SSC_MCLK_STOP_CNT) begin
            st_nxt.quiet = 2'(st_r.quiet + 2'h1);
         end
      end else begin
         st_nxt.quiet = 2'h0;
      end
      if (st_r.ctrl[SSC_CTRL_STBY] && !st_r.ctrl[SSC_CTRL_MCLK] &&
          st_r.quiet == SSC_MCLK_STOP_CNT) begin
         st_nxt.mclk = 1'b0;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r      <= '0;
         st_r.ctrl <= SSC_CTRL_RST;
         st_r.mclk <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

endmodule // ssc_host

// [ssc_monitor.sv]
/*
 * ssc_monitor: concurrent checks on the pins between sensor end and host end.
 * assumes: instantiated beside the link interface; one clock domain, pclk.
 */
`timescale 1ns/1ps
module ssc_monitor
   import ssc_pkg::*;
(
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic [9:0] pix_data,
   input wire logic [9:0] pix_data_oe_n,
   input wire logic       frame_qual,
   input wire logic       frame_qual_oe_n,
   input wire logic       line_qual,
   input wire logic       line_qual_oe_n,
   input wire logic       pixel_clock_out,
   input wire logic       pixel_clock_oe_n,
   input wire logic       strobe_out,
   input wire logic       strobe_oe_n,
   input wire logic       diff_oe_n,
   input wire logic       low_power_req,
   input wire logic       master_clock_run,
   input wire logic       reg_req,
   input wire logic       reg_ack
);
   logic [2:0] lo_cnt;
   logic [2:0] hi_cnt;
   logic       quiet;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   ////////////////////////////////////////////////////////////////////////////////
   // run lengths of the master clock level; saturate so long stops stay visible
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lo_cnt <= 3'h0;
         hi_cnt <= 3'h0;
      end else begin
         lo_cnt <= master_clock_run ? 3'h0 : lo_cnt + 3'(lo_cnt != 3'h7);
         hi_cnt <= master_clock_run ? hi_cnt + 3'(hi_cnt != 3'h7) : 3'h0;
      end
   end

   // both qualifiers low; the host may only stop the clock after two of these
   assign quiet = !frame_qual && !line_qual;

   ////////////////////////////////////////////////////////////////////////////////
   // pixel clock held high over two samples only happens in standby
   sequence s_held;
      pixel_clock_out ##1 pixel_clock_out;
   endsequence

   property p_par_oe;
      diff_oe_n |-> pix_data_oe_n == {10{line_qual_oe_n}} && frame_qual_oe_n == line_qual_oe_n
         && pixel_clock_oe_n == line_qual_oe_n && strobe_oe_n == line_qual_oe_n;
   endproperty
   property p_ser_oe;
      !diff_oe_n |-> pix_data_oe_n == 10'h3FF && frame_qual_oe_n && line_qual_oe_n
         && pixel_clock_oe_n && !strobe_oe_n;
   endproperty
   property p_stby_levels;
      s_held |-> pix_data == 10'h000 && !frame_qual && !line_qual && !strobe_out;
   endproperty
   property p_ack_run;
      $rose(reg_req) && hi_cnt >= 3'h3 |=> reg_ack;
   endproperty
   property p_no_ack_stopped;
      lo_cnt >= 3'h4 |-> !reg_ack;
   endproperty
   property p_ack_pulse;
      reg_ack |=> !reg_ack;
   endproperty
   property p_clk_stop;
      $fell(master_clock_run) |-> low_power_req && $past(quiet) && $past(quiet, 2);
   endproperty
   property p_pin_release;
      $fell(low_power_req) |-> $past(master_clock_run) && master_clock_run;
   endproperty

   a_par_oe:         assert property (p_par_oe) else $error("parallel enables disagree");
   a_ser_oe:         assert property (p_ser_oe) else $error("serial mode enables wrong");
   a_stby_levels:    assert property (p_stby_levels) else $error("standby levels wrong");
   a_ack_run:        assert property (p_ack_run) else $error("register access not answered");
   a_no_ack_stopped: assert property (p_no_ack_stopped) else $error("answer with clock stopped");
   a_ack_pulse:      assert property (p_ack_pulse) else $error("register answer too long");
   a_clk_stop:       assert property (p_clk_stop) else $error("master clock stopped too early");
   a_pin_release:    assert property (p_pin_release) else $error("pin released before clock");

   c_clk_stop: cover property ($fell(master_clock_run));
   c_held:     cover property (s_held);
   c_ack:      cover property (reg_ack && low_power_req);
endmodule // ssc_monitor

// [test_sensor_standby_output_ctrl.sv]
/*
 * test_sensor_standby_output_ctrl: sensor end and host end joined by the link;
 * the bench speaks APB to the host and watches the pins and sensor status.
 * assumes: pclk at 40 MHz; host answers with pready; sensor regs via CMD word.
 */
`timescale 1ns/1ps
module test_sensor_standby_output_ctrl
   import ssc_pkg::*;
();
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        serial_mode;
   logic        strobe_req;
   logic [3:0]  dom_clk_en;
   logic        analog_on;
   logic        bias_on;
   logic        standby_active;
   logic        tc_restart;
   logic [31:0] q;
   logic [15:0] r;
   logic        drv;
   int          num_errors;
   int          checks;
   int          restarts = 0;
   int          n0;

   ssc_link_if link();
   ssc_sensor i_ssc_sensor (.pclk(pclk), .presetn(presetn), .link(link.dev),
      .serial_mode(serial_mode), .strobe_req(strobe_req), .dom_clk_en(dom_clk_en),
      .analog_on(analog_on), .bias_on(bias_on), .standby_active(standby_active),
      .tc_restart(tc_restart));
   ssc_host i_ssc_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link(link.host));
   ssc_monitor i_ssc_monitor (.pclk(pclk), .presetn(presetn), .pix_data(link.pix_data),
      .pix_data_oe_n(link.pix_data_oe_n), .frame_qual(link.frame_qual),
      .frame_qual_oe_n(link.frame_qual_oe_n), .line_qual(link.line_qual),
      .line_qual_oe_n(link.line_qual_oe_n), .pixel_clock_out(link.pixel_clock_out),
      .pixel_clock_oe_n(link.pixel_clock_oe_n), .strobe_out(link.strobe_out),
      .strobe_oe_n(link.strobe_oe_n), .diff_oe_n(link.diff_oe_n),
      .low_power_req(link.low_power_req), .master_clock_run(link.master_clock_run),
      .reg_req(link.reg_req), .reg_ack(link.reg_ack));

   ////////////////////////////////////////////////////////////////////////////////
   // free-running pclk, 25 ns period
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   // restart pulses counted so exits can be checked after the fact; the falling
   // edge sees the settled pulse, so no race with the launching edge
   always @(negedge pclk) if (tc_restart === 1'b1) restarts <= restarts + 1;

   ////////////////////////////////////////////////////////////////////////////////
   task chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task wrap_up;
      if (num_errors == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // one APB transfer; the leading edge keeps an idle cycle between transfers
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] o);
      int n;
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 100);
      chk(32'({pready, pslverr}), 32'h2);
      o = prdata;
      psel <= 1'b0; penable <= 1'b0;
   endtask

   // poll until idle, then one more read so the data word has surely landed
   task poll(output logic [31:0] o);
      for (int n = 0; n < 50; n++) begin
         apb(1'b0, SSC_APB_STATUS, 32'h0, o);
         if (o[SSC_ST_BUSY] === 1'b0) break;
      end
      apb(1'b0, SSC_APB_STATUS, 32'h0, o);
      chk(32'(o[SSC_ST_BUSY]), 32'h0);
   endtask

   task sreg(input logic w, input logic [7:0] a, input logic [15:0] d, output logic [15:0] o);
      logic [31:0] t;
      apb(1'b1, SSC_APB_CMD, {7'h00, w, d, a}, t);
      poll(t);
      o = t[31:16];
   endtask

   // s 0 waits on standby_active, s 1 on the master clock run level; looked at on
   // the falling edge where levels have settled, then back to a rising edge
   task wait_on(input int s, input logic v);
      logic x;
      for (int n = 0; n < 500; n++) begin
         @(negedge pclk);
         x = (s == 1) ? link.master_clock_run : standby_active;
         if (x === v) break;
      end
      chk(32'(x), 32'(v));
      @(posedge pclk);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // a hang counts as a failure and ends through the same closing task
   initial begin
      repeat (40000) @(posedge pclk);
      num_errors++;
      wrap_up;
   end

   initial begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
      pwdata = 32'h0; serial_mode = 1'b0; strobe_req = 1'b0;
      num_errors = 0; checks = 0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, SSC_APB_CTRL, 32'h0, q); chk(q, 32'(SSC_CTRL_RST));
      // readout is already in row 0, column 2: both qualifiers stand high
      apb(1'b0, SSC_APB_STATUS, 32'h0, q); chk(32'(q[3:0]), 32'hE);
      apb(1'b0, 8'h0C, 32'h0, q); chk(q, 32'h0);
      sreg(1'b0, SSC_REG_OUT_CTRL, 16'h0, r); chk(32'(r), 32'(SSC_OUT_CTRL_RST));
      sreg(1'b0, SSC_REG_CLK_BYP, 16'h0, r); chk(32'(r), 32'(SSC_CLK_BYP_RST));
      sreg(1'b1, 8'h33, 16'hBEEF, r); sreg(1'b0, 8'h33, 16'h0, r); chk(32'(r), 32'h0);
      // every pin, disable and force combination, with the pin ignored for entry
      for (int i = 0; i < 8; i++) begin
         sreg(1'b1, SSC_REG_OUT_CTRL, {8'h00, 1'b1, i[2], 1'b0, i[1], 4'h0}, r);
         apb(1'b1, SSC_APB_CTRL, {30'h0, 1'b1, i[0]}, q);
         repeat (3) @(posedge pclk);
         drv = !i[1] && (i[2] || !i[0]);
         chk(32'(link.pix_data_oe_n), 32'({10{!drv}}));
         chk(32'(standby_active), 32'h0);
      end
      apb(1'b1, SSC_APB_CTRL, 32'h2, q);
      // a pin request withdrawn at once still runs the whole sequence
      sreg(1'b1, SSC_REG_OUT_CTRL, 16'h0040, r);
      n0 = restarts;
      apb(1'b1, SSC_APB_CTRL, 32'h3, q); apb(1'b1, SSC_APB_CTRL, 32'h2, q);
      wait_on(0, 1'b1);
      wait_on(0, 1'b0);
      repeat (8) @(posedge pclk);
      chk(32'(restarts - n0), 32'h1);
      // pin standby held, registers still answered
      apb(1'b1, SSC_APB_CTRL, 32'h3, q); wait_on(0, 1'b1);
      strobe_req <= 1'b1;
      repeat (20) @(posedge pclk);
      chk(32'(standby_active), 32'h1);
      chk(32'({bias_on, analog_on, dom_clk_en}), 32'h0);
      chk(32'({link.pix_data, link.frame_qual, link.line_qual, link.strobe_out,
               link.pixel_clock_out}), 32'h1);
      strobe_req <= 1'b0;
      sreg(1'b0, SSC_REG_OUT_CTRL, 16'h0, r); chk(32'(r), 32'h40);
      n0 = restarts;
      apb(1'b1, SSC_APB_CTRL, 32'h2, q); wait_on(0, 1'b0);
      repeat (8) @(posedge pclk);
      chk(32'(restarts - n0), 32'h1);
      chk(32'({bias_on, analog_on}), 32'h3);
      // register standby with gating bypassed, serial mode inside it
      sreg(1'b1, SSC_REG_CLK_BYP, 16'h0001, r);
      sreg(1'b1, SSC_REG_OUT_CTRL, 16'h0044, r); wait_on(0, 1'b1);
      chk(32'(dom_clk_en), 32'hF);
      serial_mode <= 1'b1;
      repeat (2) @(posedge pclk);
      chk(32'({link.pix_data_oe_n, link.frame_qual_oe_n, link.line_qual_oe_n,
               link.pixel_clock_oe_n, link.strobe_oe_n, link.diff_oe_n,
               link.diff_out}), 32'hFFF8);
      serial_mode <= 1'b0;
      sreg(1'b1, SSC_REG_OUT_CTRL, 16'h0040, r); wait_on(0, 1'b0);
      sreg(1'b1, SSC_REG_CLK_BYP, 16'h0000, r);
      // restart bit pulses timing restart and reads back clear
      n0 = restarts;
      sreg(1'b1, SSC_REG_OUT_CTRL, 16'h0042, r); sreg(1'b0, SSC_REG_OUT_CTRL, 16'h0, r);
      chk(32'(r), 32'h40);
      chk(32'(restarts - n0), 32'h1);
      // master clock stopped: access waits until the clock is back
      apb(1'b1, SSC_APB_CTRL, 32'h1, q); wait_on(1, 1'b0);
      apb(1'b1, SSC_APB_CMD, {16'h0000, 8'h00, SSC_REG_OUT_CTRL}, q);
      repeat (20) @(posedge pclk);
      apb(1'b0, SSC_APB_STATUS, 32'h0, q); chk(32'(q[SSC_ST_BUSY]), 32'h1);
      apb(1'b1, SSC_APB_CTRL, 32'h2, q); wait_on(1, 1'b1);
      poll(q); chk(32'(q[31:16]), 32'h40);
      wait_on(0, 1'b0);
      wrap_up;
   end
endmodule // test_sensor_standby_output_ctrl
